// ==== core/aepr_flags.v ====
// Behaviour
// [RL1] A read that drops the selected queue to its boundary pulls the flag low two cycles later.
// [RL2] A write that lifts the selected queue releases the flag two cycles after the sync window.
// [RL3] Bus bit rises after n+2 writes when the read port shares the queue, else n+1, scaled.
// [RL4] Offset n is 8 when the strap is low at reset and 128 when it is high.
// [RL5] A read reaching the boundary pulls the queue's bus bit low two cycles later.
// [RL6] A write lifting a queue raises its bus bit two cycles after the sync window.
// [RL7] A read-port queue switch may delay a bus bit change by one extra cycle.
// [RL8] Packet-ready falls when the first end marker follows an earlier start marker.
// [RL9] Packet-ready falls two cycles after the sync window following the end marker write.
// [RL10] The packet-ready bus bit follows the same timing as the discrete flag.
// [RL11] Packet-ready rises when the last receive start marker is read and no packet remains.
// [RL12] Packet-ready rises two cycles after the read of that last start marker.
// [RL13] Both edges of packet-ready flag and bus bits change only on the read clock.
// [RL14] The shared status bus is eight bits, showing eight queues at a time.
// [RL15] Write events enter the read domain through a two-stage synchroniser.
`timescale 1ns/1ps
`include "aepr_map.vh"

module aepr_flags #(
  parameter NQ = 32,
  parameter QW = 5,
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire default_offset_select,
  input wire wr_evt_toggle,
  input wire [QW-1:0] wr_evt_queue,
  input wire transmit_start_marker,
  input wire transmit_end_marker,
  input wire rd_en,
  input wire [QW-1:0] rd_queue,
  input wire receive_start_marker,
  output reg almost_empty_flag,
  output reg packet_ready_flag,
  output reg [7:0] almost_empty_status_bus,
  output reg [7:0] packet_ready_status_bus
);

  integer i;

  // Control registers
  reg [5:0] ctrl_q;
  reg [15:0] offset_q;
  reg [1:0] strap_cnt_q;
  reg strap_done_q;

  // Write-side synchroniser stages
  reg [QW+2:0] wsync1_q;
  reg [QW+2:0] wsync2_q;
  reg wtgl_prev_q;

  // Per-queue state
  reg [CW-1:0] occ_q [0:NQ-1];
  reg [CW-1:0] pkt_q [0:NQ-1];
  reg [NQ-1:0] open_q;
  reg [NQ-1:0] ae_st_q;
  reg [NQ-1:0] pr_st_q;

  // Strap synchroniser
  reg dos1_q;
  reg dos2_q;

  wire wr_hit;
  wire [QW-1:0] wq;
  wire w_transmit_start_marker;
  wire w_transmit_end_marker;
  wire [1:0] in_mode;
  wire [1:0] out_mode;
  wire [1:0] quad;
  reg [2:0] wunits;
  reg [2:0] runits;
  reg [CW-1:0] thr_base;

  // Per-queue strobes shared by the bookkeeping
  integer j;
  integer k;
  reg [NQ-1:0] wsel;
  reg [NQ-1:0] rsel;
  reg [NQ-1:0] racc;
  reg [NQ-1:0] rdec;
  wire [CW-1:0] wunits_w;
  wire [CW-1:0] runits_w;
  wire strap_take;

  // Quadrant view and selected-queue view of the status stage
  reg [7:0] ae_quad;
  reg [7:0] pr_quad;
  reg sel_ae;
  reg sel_pr;

  assign in_mode = ctrl_q[`AEPR_CTRL_IN_LSB +: 2];
  assign out_mode = ctrl_q[`AEPR_CTRL_OUT_LSB +: 2];
  assign quad = ctrl_q[`AEPR_CTRL_QUAD_LSB +: 2];
  assign wunits_w = {{(CW-3){1'b0}}, wunits};
  assign runits_w = {{(CW-3){1'b0}}, runits};

  // Only the second stage is read; the first stage feeds nothing else
  assign wr_hit = wsync2_q[QW+2] ^ wtgl_prev_q; // see [RL15]
  assign wq = wsync2_q[QW-1:0];
  assign w_transmit_start_marker = wsync2_q[QW];
  assign w_transmit_end_marker = wsync2_q[QW+1];

  // Units per word on the write port, so mixed widths share one counter
  always @* begin
    case (in_mode)
      `AEPR_W18: wunits = `AEPR_U18;
      `AEPR_W9: wunits = `AEPR_U9;
      default: wunits = `AEPR_U36;
    endcase
    // Boundary of n+1 36-bit words expressed in 9-bit units, whatever the input width
    thr_base = (offset_q + 16'h0001) << 2; // see [RL3]
  end

  // Units per word on the read port
  always @* begin
    case (out_mode)
      `AEPR_W18: runits = `AEPR_U18;
      `AEPR_W9: runits = `AEPR_U9;
      default: runits = `AEPR_U36;
    endcase
  end

  // Per-queue strobes; a read of a queue short of one output word is dropped
  always @* begin
    wsel = {NQ{1'b0}};
    rsel = {NQ{1'b0}};
    racc = {NQ{1'b0}};
    rdec = {NQ{1'b0}};
    for (j = 0; j < NQ; j = j + 1) begin
      wsel[j] = wr_hit && (wq == j[QW-1:0]);
      rsel[j] = rd_en && (rd_queue == j[QW-1:0]);
      racc[j] = rsel[j] && (occ_q[j] >= runits_w);
      // A start-marker read only counts when the word really leaves the queue
      rdec[j] = racc[j] && receive_start_marker && (pkt_q[j] != {CW{1'b0}});
    end
  end

  // Write events cross as a toggle plus steady side-band bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsync1_q <= {(QW+3){1'b0}};
      wsync2_q <= {(QW+3){1'b0}};
      wtgl_prev_q <= 1'b0;
    end else begin
      wsync1_q <= {wr_evt_toggle, transmit_end_marker, transmit_start_marker,
                   wr_evt_queue}; // see [RL15]
      wsync2_q <= wsync1_q;
      wtgl_prev_q <= wsync2_q[QW+2];
    end
  end

  // Strap sampled a fixed number of cycles after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dos1_q <= 1'b0;
      dos2_q <= 1'b0;
    end else begin
      dos1_q <= default_offset_select;
      dos2_q <= dos1_q;
    end
  end

  // Strap counter runs once after reset; the offset register takes the pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == `AEPR_STRAP_WAIT) begin
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end
  assign strap_take = !strap_done_q && (strap_cnt_q == `AEPR_STRAP_WAIT);

  // APB slave: one wait state so every answer comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_q <= `AEPR_CTRL_RST;
      offset_q <= `AEPR_N_DF_LOW;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (strap_take) begin
        offset_q <= dos2_q ? `AEPR_N_DF_HIGH : `AEPR_N_DF_LOW; // see [RL4]
      end
      if (psel & penable & ~pready) begin
        case (paddr)
          `AEPR_CTRL_OFS: begin
            prdata <= {26'h0000000, ctrl_q};
            if (pwrite) begin
              ctrl_q <= pwdata[5:0];
            end
          end
          `AEPR_OFFSET_OFS: begin
            prdata <= {16'h0000, offset_q};
            // A write before the strap is taken would be overwritten, so it is ignored
            if (pwrite && strap_done_q) begin
              offset_q <= pwdata[15:0];
            end
          end
          `AEPR_STATUS_OFS: begin
            prdata <= {8'h00, strap_done_q, rd_queue, packet_ready_status_bus,
                       almost_empty_status_bus, packet_ready_flag, almost_empty_flag};
          end
          `AEPR_AE_VEC_OFS: begin
            prdata <= ae_st_q;
          end
          `AEPR_PR_VEC_OFS: begin
            prdata <= pr_st_q;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Occupancy and packet bookkeeping per queue
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NQ; i = i + 1) begin
        occ_q[i] <= {CW{1'b0}};
        pkt_q[i] <= {CW{1'b0}};
      end
      open_q <= {NQ{1'b0}};
    end else begin
      for (i = 0; i < NQ; i = i + 1) begin
        // Occupancy: add a write, drop an accepted read, or both in one cycle
        if (wsel[i] && racc[i]) begin
          occ_q[i] <= occ_q[i] + wunits_w - runits_w;
        end else if (wsel[i]) begin
          occ_q[i] <= occ_q[i] + wunits_w; // see [RL2]
        end else if (racc[i]) begin
          occ_q[i] <= occ_q[i] - runits_w; // see [RL1]
        end
        // Packets: an end marker closes a packet only after or with a start marker
        if (wsel[i] && w_transmit_end_marker && (open_q[i] || w_transmit_start_marker)) begin
          open_q[i] <= 1'b0;
          // A start-marker read in the same cycle cancels the new packet
          if (!rdec[i]) begin
            pkt_q[i] <= pkt_q[i] + {{(CW-1){1'b0}}, 1'b1}; // see [RL8]
          end
        end else begin
          if (wsel[i] && w_transmit_start_marker) begin
            open_q[i] <= 1'b1;
          end
          if (rdec[i]) begin
            pkt_q[i] <= pkt_q[i] - {{(CW-1){1'b0}}, 1'b1}; // see [RL11]
          end
        end
      end
    end
  end

  // Status stage: high means above the boundary or no packet ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_st_q <= {NQ{1'b0}};
      pr_st_q <= {NQ{1'b1}};
    end else begin
      for (i = 0; i < NQ; i = i + 1) begin
        // The read port holds one extra word of a shared queue, so the
        // boundary moves by a word; a switch shifts it and can cost a cycle
        if (rd_queue == i[QW-1:0]) begin
          ae_st_q[i] <= occ_q[i] >= thr_base + 16'h0004; // see [RL3] see [RL7]
        end else begin
          ae_st_q[i] <= occ_q[i] >= thr_base; // see [RL6]
        end
        pr_st_q[i] <= pkt_q[i] == {CW{1'b0}}; // see [RL9] see [RL12]
      end
    end
  end

  // Quadrant picker for the shared bus; a plain case keeps the mux obvious
  always @* begin
    case (quad)
      2'h1: begin
        ae_quad = ae_st_q[15:8];
        pr_quad = pr_st_q[15:8];
      end
      2'h2: begin
        ae_quad = ae_st_q[23:16];
        pr_quad = pr_st_q[23:16];
      end
      2'h3: begin
        ae_quad = ae_st_q[31:24];
        pr_quad = pr_st_q[31:24];
      end
      default: begin
        ae_quad = ae_st_q[7:0];
        pr_quad = pr_st_q[7:0];
      end
    endcase
  end

  // Discrete flags follow the queue selected on the read port
  always @* begin
    // Idle levels stand if rd_queue names a queue that is not built
    sel_ae = 1'b0;
    sel_pr = 1'b1;
    for (k = 0; k < NQ; k = k + 1) begin
      if (rd_queue == k[QW-1:0]) begin
        sel_ae = ae_st_q[k];
        sel_pr = pr_st_q[k];
      end
    end
  end

  // Output stage on the read clock only, giving two cycles from a read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almost_empty_flag <= 1'b0;
      packet_ready_flag <= 1'b1;
      almost_empty_status_bus <= 8'h00;
      packet_ready_status_bus <= 8'hff;
    end else begin
      almost_empty_flag <= sel_ae; // see [RL1] see [RL2]
      packet_ready_flag <= sel_pr; // see [RL13]
      almost_empty_status_bus <= ae_quad; // see [RL5] see [RL14]
      packet_ready_status_bus <= pr_quad; // see [RL10] see [RL13]
    end
  end

endmodule // aepr_flags

// ==== core/aepr_map.vh ====
`ifndef AEPR_MAP_VH
`define AEPR_MAP_VH
// Register byte offsets on APB
`define AEPR_CTRL_OFS 12'h000
`define AEPR_OFFSET_OFS 12'h004
`define AEPR_STATUS_OFS 12'h008
`define AEPR_AE_VEC_OFS 12'h00c
`define AEPR_PR_VEC_OFS 12'h010
// Control fields
`define AEPR_CTRL_IN_LSB 0
`define AEPR_CTRL_OUT_LSB 2
`define AEPR_CTRL_QUAD_LSB 4
`define AEPR_CTRL_RST 6'h00
// Bus width modes: 0 = 36 bits, 1 = 18 bits, 2 = 9 bits
`define AEPR_W36 2'h0
`define AEPR_W18 2'h1
`define AEPR_W9 2'h2
// Occupancy units per word: a 36-bit word is four 9-bit units
`define AEPR_U36 3'h4
`define AEPR_U18 3'h2
`define AEPR_U9 3'h1
// Almost-empty offset defaults, picked by the strap at reset
`define AEPR_N_DF_LOW 16'h0008
`define AEPR_N_DF_HIGH 16'h0080
// Cycles after reset release before the strap is trusted
`define AEPR_STRAP_WAIT 2'h2
`endif

// ==== verification/aepr_flags_bench.sv ====
`timescale 1ns/1ps
module aepr_flags_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic default_offset_select = 1'b0, wr_evt_toggle = 1'b0, go = 1'b0, rsm = 1'b0;
  logic transmit_start_marker = 1'b0, transmit_end_marker = 1'b0;
  logic [4:0] wr_evt_queue = 5'h00, qsel = 5'h00, rd_queue;
  logic [31:0] prdata;
  logic pready, pslverr, rd_en, receive_start_marker, almost_empty_flag, packet_ready_flag;
  logic [7:0] almost_empty_status_bus, packet_ready_status_bus;
  int occ[8], pkt[8], n, rdq, fails, n_compared;
  int wu, ru;
  bit opn[8];
  wire [31:0] seen = {14'h0, almost_empty_flag, packet_ready_flag, almost_empty_status_bus,
    packet_ready_status_bus};
  always #2 pclk = ~pclk;
  aepr_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .default_offset_select(default_offset_select),
    .wr_evt_toggle(wr_evt_toggle), .wr_evt_queue(wr_evt_queue),
    .transmit_start_marker(transmit_start_marker), .transmit_end_marker(transmit_end_marker),
    .rd_en(rd_en), .rd_queue(rd_queue), .receive_start_marker(receive_start_marker),
    .almost_empty_flag(almost_empty_flag), .packet_ready_flag(packet_ready_flag),
    .almost_empty_status_bus(almost_empty_status_bus),
    .packet_ready_status_bus(packet_ready_status_bus));
  aepr_reader i_rdr (.pclk(pclk), .go(go), .rsm(rsm), .q(qsel), .rd_en(rd_en),
    .rd_queue(rd_queue), .receive_start_marker(receive_start_marker));
  // Model view: {flag ae, flag pr, ae bus, pr bus}; shared queue needs one word more
  function automatic logic [31:0] expv();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 8; i++) begin
      v[i+8] = occ[i] >= 4 * (n + 1) + (i == rdq ? 4 : 0);
      v[i] = pkt[i] == 0;
    end
    v[17] = v[8+rdq];
    v[16] = v[rdq];
    return v;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    default_offset_select <= s;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (occ[i]) begin
      occ[i] = 0;
      pkt[i] = 0;
      opn[i] = 0;
    end
    n = s ? 128 : 8;
    wu = 4;
    ru = 4;
    tick(4);
    chk(seen, expv());
  endtask
  // Queue and markers settle three cycles before the toggle
  task automatic wr(input int q, input logic s, input logic t);
    logic [31:0] old;
    @(posedge pclk);
    wr_evt_queue <= q[4:0];
    transmit_start_marker <= s;
    transmit_end_marker <= t;
    repeat (3) @(posedge pclk);
    wr_evt_toggle <= ~wr_evt_toggle;
    old = expv();
    occ[q] += wu;
    if (s) opn[q] = 1;
    if (t && opn[q]) begin
      pkt[q]++;
      opn[q] = 0;
    end
    tick(4);
    chk(seen, old);
    tick(1);
    chk(seen, expv());
  endtask
  task automatic rd(input logic m);
    logic [31:0] old;
    @(posedge pclk);
    go <= 1'b1;
    rsm <= m;
    @(posedge pclk);
    go <= 1'b0;
    old = expv();
    if (occ[rdq] >= ru) begin
      occ[rdq] -= ru;
      if (m && pkt[rdq] > 0) pkt[rdq]--;
    end
    tick(2);
    chk(seen, old);
    tick(1);
    chk(seen, expv());
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    int unsigned x;
    void'($urandom(80911));
    rst(1'b0);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r, 32'h8);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    rst(1'b1);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk(r, 32'h80);
    apb(1'b1, 12'h004, 32'h1, r, e);
    n = 1;
    for (int i = 0; i < 24; i++) begin
      x = $urandom;
      wr(x % 3, x[3], x[4]);
    end
    repeat (12) rd(1'($urandom % 2));
    @(posedge pclk);
    qsel <= 5'h01;
    rdq = 1;
    tick(6);
    chk(seen, expv());
    repeat (10) rd(1'($urandom % 2));
    // Narrow ports: 18-bit words in and out, two units each
    apb(1'b1, 12'h000, 32'h5, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h5);
    wu = 2;
    ru = 2;
    for (int i = 0; i < 8; i++) begin
      x = $urandom;
      wr(x % 3, x[3], x[4]);
    end
    repeat (6) rd(1'($urandom % 2));
    close_out();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end
endmodule // aepr_flags_bench

// ==== verification/aepr_flags_properties.sv ====
`timescale 1ns/1ps
module aepr_chk #(
  parameter QW = 5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire wr_evt_toggle,
  input wire rd_en,
  input wire [QW-1:0] rd_queue,
  input wire receive_start_marker,
  input wire almost_empty_flag,
  input wire packet_ready_flag,
  input wire [7:0] almost_empty_status_bus
);
  reg [6:0] tg_q;
  reg [3:0] qc_q;
  reg [QW-1:0] qp_q;
  // History of the write toggle and of read queue switches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tg_q <= 7'h00;
      qc_q <= 4'hf;
      qp_q <= {QW{1'b0}};
    end else begin
      tg_q <= {tg_q[5:0], wr_evt_toggle};
      qc_q <= {qc_q[2:0], qp_q != rd_queue};
      qp_q <= rd_queue;
    end
  end
  // A switch may add a cycle, so edges near one are not judged
  wire q_ok = ~|qc_q & (qp_q == rd_queue);
  wire wch = (tg_q[4] ^ tg_q[5]) | (tg_q[5] ^ tg_q[6]);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("data not idle");
  ae_fall_read_a: assert property ($fell(almost_empty_flag) && q_ok |-> $past(rd_en, 3))
    else $error("flag fell without read");
  ae_rise_write_a: assert property ($rose(almost_empty_flag) && q_ok |-> wch)
    else $error("flag rose off time");
  pr_rise_read_a: assert property ($rose(packet_ready_flag) && q_ok |->
    $past(rd_en && receive_start_marker, 3)) else $error("packet flag rose off time");
  pr_fall_write_a: assert property ($fell(packet_ready_flag) && q_ok |-> wch)
    else $error("packet flag fell off time");
  bus_fall_read_a: assert property (
    |($past(almost_empty_status_bus) & ~almost_empty_status_bus) && q_ok |-> $past(rd_en, 3))
    else $error("bus bit fell without read");
  cover property ($fell(almost_empty_flag));
  cover property ($fell(packet_ready_flag));
  cover property ($rose(packet_ready_flag));
  cover property (pslverr);
endmodule // aepr_chk
bind aepr_flags aepr_chk #(.QW(QW)) i_chk (.*);

// ==== verification/aepr_reader.sv ====
`timescale 1ns/1ps
module aepr_reader (
  input wire pclk,
  input wire go,
  input wire rsm,
  input wire [4:0] q,
  output reg rd_en,
  output reg [4:0] rd_queue,
  output reg receive_start_marker
);
  initial begin
    rd_en = 1'b0;
    rd_queue = 5'h00;
    receive_start_marker = 1'b0;
  end
  // One read pulse per request; marker flips when no read so it is never trusted idle
  always @(posedge pclk) begin
    rd_en <= go;
    rd_queue <= q;
    receive_start_marker <= go ? rsm : ~receive_start_marker;
  end
endmodule // aepr_reader
